//--- logic/ehb_bridge.sv
/*
  Hex command bridge: line parser, command sequencer, SPI master and the
  transmit FIFO. Assumes serial bytes arrive already deframed, one per
  RX_VALID pulse, and the converter speaks SPI mode 0 with a read bit in
  the address MSB.
*/
`timescale 1ns/100ps
`include "ehb_params.svh"

module ehb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `EHB_FIFO_DEPTH,
    parameter int AW    = `EHB_FIFO_AW
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
    logic             push, pop;

    // Extra pointer bit tells full from empty
    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
        out_valid = wr_reg != rd_reg;
        out_data = mem[rd_reg[AW-1:0]];
        wr_next  = push ? wr_reg + 1'b1 : wr_reg;
        rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

module ehb_bridge
    import ehb_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    // Serial receive bytes
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_VALID,
    // Serial transmit bytes
    output logic [7:0]      TX_DATA,
    output logic            TX_VALID,
    input  wire logic       TX_READY,
    // Converter SPI
    output logic            SPI_SCLK,
    output logic            SPI_CS_N,
    output logic            SPI_MOSI,
    input  wire logic       SPI_MISO,
    // Boot loader hand-off
    output logic            BOOT_REQ
);
    function automatic logic is_hex(input logic [7:0] c);
        is_hex = (c >= "0" && c <= "9") || (c >= "A" && c <= "F") || (c >= "a" && c <= "f");
    endfunction

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (c <= "9") v = c - "0";
        else if (c <= "F") v = c - "A" + 8'h0a;
        else v = c - "a" + 8'h0a;
        hex_val = v[3:0];
    endfunction

    function automatic logic [7:0] stream_reg(input logic hires, input logic [2:0] i);
        logic [7:0] r;
        r = 8'h00;
        case ({hires, i})
            4'h0: r = `EHB_ADR_RES_STAT;   // resistance_status_reg
            4'h1: r = `EHB_ADR_RES_HIGH;   // resistance_result_high
            4'h2: r = `EHB_ADR_RES_LOW;    // resistance_result_low
            4'h3: r = `EHB_ADR_IND_HIGH;   // Inductance high
            4'h4: r = `EHB_ADR_IND_LOW;    // Inductance low
            4'h8: r = `EHB_ADR_HR_STAT;    // hires_status_reg
            4'h9: r = `EHB_ADR_HR_HIGH;    // hires_result_high
            4'ha: r = `EHB_ADR_HR_MID;     // hires_result_middle
            4'hb: r = `EHB_ADR_HR_LOW;     // hires_result_low
            default: r = 8'h00;
        endcase
        stream_reg = r;
    endfunction

    // Line parser state
    logic [7:0] ch_reg [`EHB_LINE_MAX];
    logic [7:0] ch_next [`EHB_LINE_MAX];
    logic [2:0] cnt_reg, cnt_next;
    logic       cr_reg, cr_next;
    logic       stb_reg, stb_next;

    // Keep at most six characters; longer lines keep their head only
    always_comb begin
        for (int i = 0; i < `EHB_LINE_MAX; i++) ch_next[i] = ch_reg[i];
        cnt_next = cnt_reg;
        cr_next  = cr_reg;
        stb_next = 1'b0;
        if (RX_VALID) begin
            if (RX_DATA == `EHB_CHAR_CR) begin
                cr_next = 1'b1;
            end else if (RX_DATA == `EHB_CHAR_LF && cr_reg) begin
                stb_next = 1'b1;
                cnt_next = 3'h0;
                cr_next  = 1'b0;
            end else begin
                cr_next = 1'b0;
                if (cnt_reg < `EHB_LINE_MAX) begin
                    ch_next[cnt_reg] = RX_DATA;
                    cnt_next = cnt_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int i = 0; i < `EHB_LINE_MAX; i++) ch_reg[i] <= 8'h00;
            cnt_reg <= 3'h0;
            cr_reg  <= 1'b0;
            stb_reg <= 1'b0;
        end else begin
            ch_reg  <= ch_next;
            cnt_reg <= cnt_next;
            cr_reg  <= cr_next;
            stb_reg <= stb_next;
        end
    end

    // Decoded line, held from the characters until the next line starts
    logic [2:0] len_reg;
    logic [7:0] code, addr, wdat;
    logic       code_ok, addr_ok, wdat_ok;
    always_ff @(posedge CLK_SYS) begin
        if (RST) len_reg <= 3'h0;
        else if (stb_next) len_reg <= cnt_reg;
    end
    always_comb begin
        code    = {hex_val(ch_reg[0]), hex_val(ch_reg[1])};
        addr    = {hex_val(ch_reg[2]), hex_val(ch_reg[3])};
        wdat    = {hex_val(ch_reg[4]), hex_val(ch_reg[5])};
        code_ok = len_reg >= 3'h2 && is_hex(ch_reg[0]) && is_hex(ch_reg[1]);
        addr_ok = len_reg >= `EHB_LEN_ADDR && is_hex(ch_reg[2]) && is_hex(ch_reg[3]);
        wdat_ok = len_reg >= `EHB_LINE_MAX && is_hex(ch_reg[4]) && is_hex(ch_reg[5]);
    end

    // SPI master state
    logic        spi_start;
    logic [15:0] spi_word;
    logic        busy_reg, busy_next, sclk_reg, sclk_next, csn_reg, csn_next;
    logic        mosi_reg, mosi_next, done_reg, done_next;
    logic [15:0] tx_reg, tx_next;
    logic [7:0]  rx_reg, rx_next;
    logic [2:0]  div_reg, div_next;
    logic [3:0]  bit_reg, bit_next;

    // Mode 0: sample on the rising edge, shift on the falling edge
    always_comb begin
        busy_next = busy_reg;
        sclk_next = sclk_reg;
        csn_next  = csn_reg;
        tx_next   = tx_reg;
        rx_next   = rx_reg;
        div_next  = div_reg;
        bit_next  = bit_reg;
        done_next = 1'b0;
        if (spi_start && !busy_reg) begin
            busy_next = 1'b1;
            csn_next  = 1'b0;
            tx_next   = spi_word;
            div_next  = 3'h0;
            bit_next  = 4'h0;
        end else if (busy_reg) begin
            div_next = div_reg + 3'h1;
            if (div_reg == `EHB_SPI_DIV - 3'h1) begin
                div_next = 3'h0;
                sclk_next = !sclk_reg;
                if (!sclk_reg) begin
                    rx_next = {rx_reg[6:0], SPI_MISO};
                end else begin
                    tx_next  = {tx_reg[14:0], 1'b0};
                    bit_next = bit_reg + 4'h1;
                    if (bit_reg == `EHB_SPI_LAST) begin
                        busy_next = 1'b0;
                        csn_next  = 1'b1;
                        done_next = 1'b1;
                    end
                end
            end
        end
        mosi_next = tx_next[15] && !csn_next;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            busy_reg <= 1'b0;
            sclk_reg <= 1'b0;
            csn_reg  <= 1'b1;
            mosi_reg <= 1'b0;
            done_reg <= 1'b0;
            tx_reg   <= 16'h0000;
            rx_reg   <= 8'h00;
            div_reg  <= 3'h0;
            bit_reg  <= 4'h0;
        end else begin
            busy_reg <= busy_next;
            sclk_reg <= sclk_next;
            csn_reg  <= csn_next;
            mosi_reg <= mosi_next;
            done_reg <= done_next;
            tx_reg   <= tx_next;
            rx_reg   <= rx_next;
            div_reg  <= div_next;
            bit_reg  <= bit_next;
        end
    end

    // Sequencer state
    ehb_state_e st_reg, st_next;
    ehb_op_e    op_reg, op_next;
    logic [7:0] resp_reg [`EHB_VER_LEN];
    logic [7:0] resp_next [`EHB_VER_LEN];
    logic [3:0] len_out_reg, len_out_next, eix_reg, eix_next;
    logic       run_reg, run_next, hires_reg, hires_next, boot_reg, boot_next;
    logic [8:0] rec_reg, rec_next;
    logic [7:0] idx_reg, idx_next;
    logic [2:0] rix_reg, rix_next;
    logic       fifo_ready, push;
    logic [7:0] push_data;
    logic       cmd_ok;

    // A line is acted on only when its code is known and its fields are hex
    always_comb begin
        case (code)
            `EHB_CMD_WRITE:  cmd_ok = code_ok && addr_ok && wdat_ok;
            `EHB_CMD_READ:   cmd_ok = code_ok && addr_ok;
            `EHB_CMD_STREAM: cmd_ok = code_ok && addr_ok
                                      && (addr == `EHB_MODE_RPL || addr == `EHB_MODE_HIRES);
            `EHB_CMD_BOOT, `EHB_CMD_STOP, `EHB_CMD_VER: cmd_ok = code_ok;
            default:         cmd_ok = 1'b0;
        endcase
    end

    // Busy lines other than a stop are dropped; stop lets the record finish
    always_comb begin
        st_next      = st_reg;
        op_next      = op_reg;
        resp_next    = resp_reg;
        len_out_next = len_out_reg;
        eix_next     = eix_reg;
        run_next     = run_reg;
        hires_next   = hires_reg;
        rec_next     = rec_reg;
        idx_next     = idx_reg;
        rix_next     = rix_reg;
        boot_next    = 1'b0;
        spi_start    = 1'b0;
        spi_word     = 16'h0000;
        push         = 1'b0;
        push_data    = resp_reg[eix_reg];
        if (stb_reg && cmd_ok && code == `EHB_CMD_STOP) run_next = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (stb_reg && cmd_ok) begin
                    for (int i = 0; i < `EHB_VER_LEN; i++) resp_next[i] = 8'h00;
                    len_out_next = `EHB_RESP_LEN;
                    eix_next = 4'h0;
                    case (code)
                        `EHB_CMD_WRITE: begin
                            spi_start = 1'b1;
                            spi_word  = {addr & `EHB_SPI_WR_MASK, wdat};
                            op_next   = OP_WR;
                            st_next   = ST_SPI;
                        end
                        `EHB_CMD_READ: begin
                            spi_start = 1'b1;
                            spi_word  = {addr | `EHB_SPI_RD_BIT, 8'h00};
                            op_next   = OP_RD;
                            st_next   = ST_SPI;
                        end
                        `EHB_CMD_STREAM: begin
                            hires_next = addr == `EHB_MODE_HIRES;
                            run_next = 1'b1;
                            rec_next = 9'h000;
                            idx_next = 8'h00;
                            rix_next = 3'h0;
                            op_next  = OP_STREAM;
                            st_next  = ST_REC;
                        end
                        `EHB_CMD_VER: begin
                            {resp_next[6], resp_next[7], resp_next[8], resp_next[9]}
                                = `EHB_FW_VERSION;
                            len_out_next = `EHB_VER_LEN;
                            op_next = OP_VER;
                            st_next = ST_EMIT;
                        end
                        `EHB_CMD_BOOT: boot_next = 1'b1;
                        default: ;
                    endcase
                end
            end
            ST_REC: begin
                spi_start = 1'b1;
                spi_word  = {stream_reg(hires_reg, rix_reg) | `EHB_SPI_RD_BIT, 8'h00};
                st_next   = ST_SPI;
            end
            ST_SPI: begin
                if (done_reg) begin
                    case (op_reg)
                        OP_WR: resp_next[`EHB_POS_WCONF] = tx_reg[15:8] | wdat;
                        OP_RD: resp_next[`EHB_POS_RDATA] = rx_reg;
                        default: resp_next[rix_reg] = rx_reg;
                    endcase
                    st_next = ST_EMIT;
                    if (op_reg == OP_STREAM) begin
                        rix_next = rix_reg + 3'h1;
                        if (!hires_reg && rix_reg == `EHB_RPL_READS - 3'h1) begin
                            resp_next[5] = `EHB_MARK;
                            resp_next[6] = idx_reg;
                            resp_next[7] = `EHB_MARK;
                        end else if (hires_reg && rix_reg == `EHB_HIRES_READS - 3'h1) begin
                            resp_next[4] = `EHB_MARK;
                            resp_next[5] = idx_reg;
                            resp_next[6] = `EHB_MARK;
                            resp_next[7] = `EHB_MARK;
                        end else begin
                            st_next = ST_REC;
                        end
                    end
                end
            end
            ST_EMIT: begin
                push = 1'b1;
                if (fifo_ready) begin
                    eix_next = eix_reg + 4'h1;
                    if (eix_reg == len_out_reg - 4'h1) begin
                        eix_next = 4'h0;
                        rix_next = 3'h0;
                        st_next  = ST_IDLE;
                        if (op_reg == OP_STREAM && run_next && rec_reg != `EHB_REC_LAST) begin
                            rec_next = rec_reg + 9'h001;
                            idx_next = idx_reg + 8'h01;
                            st_next  = ST_REC;
                        end else if (op_reg == OP_STREAM) begin
                            run_next = 1'b0;
                        end
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_reg      <= ST_IDLE;
            op_reg      <= OP_WR;
            for (int i = 0; i < `EHB_VER_LEN; i++) resp_reg[i] <= 8'h00;
            len_out_reg <= `EHB_RESP_LEN;
            eix_reg     <= 4'h0;
            run_reg     <= 1'b0;
            hires_reg   <= 1'b0;
            rec_reg     <= 9'h000;
            idx_reg     <= 8'h00;
            rix_reg     <= 3'h0;
            boot_reg    <= 1'b0;
        end else begin
            st_reg      <= st_next;
            op_reg      <= op_next;
            resp_reg    <= resp_next;
            len_out_reg <= len_out_next;
            eix_reg     <= eix_next;
            run_reg     <= run_next;
            hires_reg   <= hires_next;
            rec_reg     <= rec_next;
            idx_reg     <= idx_next;
            rix_reg     <= rix_next;
            boot_reg    <= boot_next;
        end
    end

    // FIFO read side is registered storage; its ready stalls emission
    ehb_fifo #(.WIDTH(8), .DEPTH(`EHB_FIFO_DEPTH), .AW(`EHB_FIFO_AW)) u_txq (
        .clk       (CLK_SYS),
        .rst       (RST),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (TX_VALID),
        .out_ready (TX_READY),
        .out_data  (TX_DATA)
    );

    assign SPI_SCLK = sclk_reg;
    assign SPI_CS_N = csn_reg;
    assign SPI_MOSI = mosi_reg;
    assign BOOT_REQ = boot_reg;

    // Checks on the sequencer and parser
    a_line_end: assert property (@(posedge CLK_SYS) disable iff (RST)
        stb_reg |-> $past(RX_VALID) && $past(RX_DATA) == `EHB_CHAR_LF)
        else $error("line ended without line feed");
    a_wr_confirm: assert property (@(posedge CLK_SYS) disable iff (RST)
        (st_reg == ST_EMIT && op_reg == OP_WR && eix_reg == 4'h1 && fifo_ready)
        |-> push_data == wdat)
        else $error("write echo not in position 1");
    a_zero_fill: assert property (@(posedge CLK_SYS) disable iff (RST)
        (st_reg == ST_EMIT && ((op_reg == OP_WR && eix_reg != `EHB_POS_WCONF)
         || (op_reg == OP_RD && eix_reg != `EHB_POS_RDATA))) |-> push_data == 8'h00)
        else $error("unused response byte not zero");
    a_rd_capture: assert property (@(posedge CLK_SYS) disable iff (RST)
        (done_reg && st_reg == ST_SPI && op_reg == OP_RD)
        |=> resp_reg[`EHB_POS_RDATA] == $past(rx_reg) && st_reg == ST_EMIT)
        else $error("read byte not in position 4");
    a_rpl_marks: assert property (@(posedge CLK_SYS) disable iff (RST)
        (st_reg == ST_EMIT && op_reg == OP_STREAM && !hires_reg
         && (eix_reg == 4'h5 || eix_reg == 4'h7)) |-> push_data == `EHB_MARK)
        else $error("resistance record marker wrong");
    a_hires_marks: assert property (@(posedge CLK_SYS) disable iff (RST)
        (st_reg == ST_EMIT && op_reg == OP_STREAM && hires_reg && eix_reg != 4'h5
         && eix_reg >= 4'h4) |-> push_data == `EHB_MARK)
        else $error("high-resolution record marker wrong");
    a_bad_no_spi: assert property (@(posedge CLK_SYS) disable iff (RST)
        (stb_reg && !cmd_ok && st_reg == ST_IDLE) |=> !busy_reg && st_reg == ST_IDLE)
        else $error("discarded line started SPI");
    a_stop_halts: assert property (@(posedge CLK_SYS) disable iff (RST)
        (stb_reg && cmd_ok && code == `EHB_CMD_STOP) |=> !run_reg)
        else $error("stop did not halt stream");
    a_boot_pulse: assert property (@(posedge CLK_SYS) disable iff (RST)
        (stb_reg && cmd_ok && code == `EHB_CMD_BOOT && st_reg == ST_IDLE)
        |=> BOOT_REQ ##1 !BOOT_REQ && st_reg == ST_IDLE)
        else $error("boot request not a single pulse");
endmodule

//--- logic/ehb_params.svh
/*
  Constants of the hex command bridge: command codes, response layout,
  stream register lists and SPI timing. Included by the design; the package does not include it.
  Assumes the includer pulls it in once per compilation unit.
*/
`ifndef EHB_PARAMS_SVH
`define EHB_PARAMS_SVH
`define EHB_CMD_WRITE   8'h02
`define EHB_CMD_READ    8'h03
`define EHB_CMD_BOOT    8'h04
`define EHB_CMD_STREAM  8'h06
`define EHB_CMD_STOP    8'h07
`define EHB_CMD_VER     8'h09
`define EHB_MODE_RPL    8'h20
`define EHB_MODE_HIRES  8'h38
`define EHB_MARK        8'h5a
// Converter registers read for each stream record
`define EHB_ADR_RES_STAT 8'h20
`define EHB_ADR_RES_HIGH 8'h22
`define EHB_ADR_RES_LOW  8'h21
`define EHB_ADR_IND_HIGH 8'h24
`define EHB_ADR_IND_LOW  8'h23
`define EHB_ADR_HR_STAT  8'h3b
`define EHB_ADR_HR_HIGH  8'h3a
`define EHB_ADR_HR_MID   8'h39
`define EHB_ADR_HR_LOW   8'h38
`define EHB_CHAR_CR     8'h0d
`define EHB_CHAR_LF     8'h0a
`define EHB_LINE_MAX    3'h6
`define EHB_LEN_ADDR    3'h4
`define EHB_RESP_LEN    4'h8
`define EHB_VER_LEN     4'ha
`define EHB_POS_WCONF   4'h1
`define EHB_POS_RDATA   4'h4
`define EHB_POS_VER     4'h6
`define EHB_REC_LAST    9'h1ff
`define EHB_RPL_READS   3'h5
`define EHB_HIRES_READS 3'h4
`define EHB_SPI_RD_BIT  8'h80
`define EHB_SPI_WR_MASK 8'h7f
`define EHB_SPI_DIV     3'h4
`define EHB_SPI_LAST    4'hf
// Firmware version value is arbitrary
`define EHB_FW_VERSION  32'h00010000
`define EHB_FIFO_DEPTH  8
`define EHB_FIFO_AW     3
`endif

//--- logic/ehb_pkg.sv
/*
  Types of the hex command bridge.
  Assumes ehb_params.svh is on the include path.
*/
package ehb_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_REC, ST_SPI, ST_EMIT} ehb_state_e;
    typedef enum logic [1:0] {OP_WR, OP_RD, OP_STREAM, OP_VER} ehb_op_e;
endpackage

//--- test/ehb_conv_model.sv
/*
  Converter model: SPI mode 0 register slave with 128 byte registers.
  Assumes a 16-bit frame, address byte first, read bit in the address MSB.
*/
`timescale 1ns/100ps
module ehb_conv_model (
    // SPI from the bridge
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    output logic      miso,
    // Frames seen, for the bench
    output int        frames
);
    logic [7:0]  mem [128];
    logic [15:0] sh = 16'h0000;
    logic [7:0]  adr = 8'h00;
    int          n = 0;
    int          cnt = 0;

    assign frames = cnt;
    // Each register starts as its address xor a5, so every read differs
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'ha5;
        miso = 1'b0;
    end
    // Shift in on the rising edge, MSB first
    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = {sh[14:0], mosi};
            n++;
            if (n == 8) adr = sh[7:0];
        end
    end
    // Read data leaves on the falling edge after the address byte
    always @(negedge sclk) begin
        if (!cs_n && n >= 8 && n < 16 && adr[7]) miso = mem[adr[6:0]][15-n];
    end
    // Frame end: a write lands; the released line never keeps its last bit
    always @(posedge cs_n) begin
        if (n > 0) begin
            if (n == 16 && !adr[7]) mem[adr[6:0]] = sh[7:0];
            cnt++;
            n = 0;
            miso = ~miso;
        end
    end
endmodule

//--- test/tb.sv
/*
  Bench of the hex command bridge: host lines in, answer bytes out.
  Assumes the bridge and the converter model are compiled first.
*/
`timescale 1ns/100ps
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] rx_data = 8'h00;
    logic       rx_valid = 1'b0;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_ready = 1'b0;
    logic       sclk, cs_n, mosi, miso, boot;
    int         frames;
    int         n_errors = 0;
    int         samples_checked = 0;
    logic [7:0] q [$];

    always #25 clk = ~clk;

    ehb_bridge i_dut (.CLK_SYS(clk), .RST(rst), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .SPI_SCLK(sclk),
        .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .BOOT_REQ(boot));
    ehb_conv_model i_conv (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .frames(frames));

    task automatic test_done();
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Byte and count comparisons
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp, input string what);
        samples_checked++;
        if (got != exp) begin
            n_errors++;
            $display("Error %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    // Model register start value, mirrored here
    function automatic logic [7:0] rv(input logic [7:0] a);
        return a ^ 8'ha5;
    endfunction
    // One byte per cycle, CR LF appended
    task automatic send(input string s);
        string t;
        t = {s, "\r\n"};
        for (int i = 0; i < t.len(); i++) begin
            @(posedge clk);
            rx_data  <= t[i];
            rx_valid <= 1'b1;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    // Takes one byte, then stalls a cycle so the FIFO backs up
    task automatic rx(output logic [7:0] b);
        for (int k = 0; k < 4000; k++) begin
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                b = tx_data;
                tx_ready <= 1'b0;
                return;
            end
            tx_ready <= 1'b1;
        end
        n_errors++;
        $display("Error %0t: no answer byte", $time);
        test_done();
    endtask
    task automatic expect_bytes(input string what);
        logic [7:0] b;
        foreach (q[i]) begin
            rx(b);
            chk(b, q[i], what);
        end
    endtask
    // Counts whatever still drains within a fixed time
    task automatic drain(input int cyc, output int cnt);
        cnt = 0;
        for (int k = 0; k < cyc; k++) begin
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) cnt++;
            tx_ready <= 1'b1;
        end
    endtask

    task automatic t_write();
        send("02316B");
        q = '{8'h00, 8'h6b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        expect_bytes("write echo");
        chk(i_conv.mem[7'h31], 8'h6b, "written register");
    endtask
    task automatic t_read(input string s, input logic [7:0] exp);
        send(s);
        q = '{8'h00, 8'h00, 8'h00, 8'h00, exp, 8'h00, 8'h00, 8'h00};
        expect_bytes("read data");
    endtask
    task automatic t_ver();
        send("09");
        q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        expect_bytes("version");
    endtask
    // Bad code, non-hex fields and an unknown stream mode start nothing
    task automatic t_bad();
        int f;
        int c;
        f = frames;
        send("0531");
        send("0G31");
        send("03X1");
        send("0621");
        drain(600, c);
        chk_n(c, 0, "bytes after bad lines");
        chk_n(frames - f, 0, "frames after bad lines");
    endtask
    // Two records, the second held back in a full FIFO, then a stop
    task automatic t_stream(input bit hr);
        int c;
        if (hr) send("0638");
        else send("0620");
        for (int r = 0; r < 2; r++) begin
            if (hr) q = '{rv(8'h3b), rv(8'h3a), rv(8'h39), rv(8'h38),
                          8'h5a, 8'(r), 8'h5a, 8'h5a};
            else q = '{rv(8'h20), rv(8'h22), rv(8'h21), rv(8'h24), rv(8'h23),
                       8'h5a, 8'(r), 8'h5a};
            if (r == 1) repeat (800) @(posedge clk);
            expect_bytes("stream record");
        end
        send("07");
        drain(2000, c);
        chk_n(c, 8, "bytes after stop");
    endtask
    task automatic t_boot();
        int p;
        int c;
        p = 0;
        send("04");
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            if (boot === 1'b1) p++;
        end
        chk_n(p, 1, "boot pulses");
        drain(300, c);
        chk_n(c, 0, "bytes after boot");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_write();
        t_read("0331", 8'h6b);
        t_read("033a", 8'h9f);
        t_ver();
        t_bad();
        t_stream(1'b0);
        t_stream(1'b1);
        t_boot();
        test_done();
    end
endmodule
